// ### core/cdo_exec.sv
// Overview of operation
// RULE1 - Zero test compares operand with zero, sets five flags, keeps operand, one cycle.
// RULE2 - Magnitude test subtracts source from base, discards it, sets five flags.
// RULE3 - Borrow test subtracts operand and inverted carry, discards result, sets flags.
// RULE4 - File form of borrow test compares file with default register, writes nothing.
// RULE5 - Equal skip skips when equal: one cycle, or two or three when skipping; flags kept.
// RULE6 - Greater, less and unequal skips time like the equal skip, flags kept.
// RULE7 - Equal branch takes one cycle, or five when taken; flags kept.
// RULE8 - Greater, less and unequal branches time like the equal branch.
// RULE9 - Bank switch by immediate selects a register context in two cycles.
// RULE10 - Bank switch by register takes context from a register, two cycles.
// RULE11 - Byte decimal adjust corrects low byte to BCD, changes only carry.
// RULE12 - Interrupt hold blocks interrupts for the next k cycles.
// RULE13 - Preserving long signed divide takes six cycles, keeps the register pair.
// RULE14 - Preserving fractional divide takes six cycles, keeps the register pair.
// RULE15 - Operands in peripheral registers add one cycle to reads.
// RULE16 - Software repeats non-preserving divides six times with a prefix.
// RULE17 - Zero out writes zero; accumulator form clears its overflow and clip flags.
// RULE18 - Minus one and two write base less one or two, set five flags.
// RULE19 - Invert writes the complement, updates only negative and zero.
`include "cdo_params.svh"
module cdo_exec #(
	parameter int HOLD_W = `CDO_HOLD_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction issue
	input wire logic op_valid,
	input wire cdo_pkg::cdo_op_e op,
	input wire logic [15:0] base_val,
	input wire logic [15:0] base_hi,
	input wire logic [15:0] src_val,
	input wire logic acc_sel,
	input wire logic op_sfr,
	input wire logic next_two_word,
	// Sequencing
	output logic op_ready,
	output logic busy,
	output logic done,
	output logic skip_taken,
	output logic branch_taken,
	// Results
	output logic [15:0] result,
	output logic result_we,
	output logic [15:0] remainder,
	output logic pair_we,
	// Processor state
	output logic [2:0] ctx,
	output logic irq_blocked,
	// Status flags
	output logic c_flag,
	output logic half_carry_flag,
	output logic n_flag,
	output logic signed_wrap_flag,
	output logic z_flag,
	output logic accum_a_overflow,
	output logic accum_b_overflow,
	output logic accum_a_clip_flag,
	output logic accum_b_clip_flag
);
	logic accept;
	logic is_div;
	logic [15:0] sub_b;
	logic sub_cin;
	logic [16:0] sub_sum;
	logic [8:0] lo_sum;
	logic sub_ov;
	logic cmp_hit;
	logic [8:0] bcd;
	logic bcd_c;
	logic upd_arith;
	logic [2:0] cnt, next_cnt;
	logic pend_we, next_pend_we;
	logic pend_pair, next_pend_pair;
	logic pend_skip, next_pend_skip;
	logic pend_br, next_pend_br;
	logic next_ready, next_busy, next_done, next_skip, next_branch;
	logic [15:0] next_result, next_remainder;
	logic next_result_we, next_pair_we;
	logic [2:0] next_ctx;
	logic next_c, next_dc, next_n, next_ov, next_z, next_oa, next_ob, next_sa, next_sb;
	logic [HOLD_W-1:0] hold, next_hold, hold_k;
	logic next_blocked;
	logic [2:0] src_ctx;

	cdo_div_if div ();

	cdo_divider u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.dv(div.engine)
	);

	assign accept = op_valid && op_ready;
	assign is_div = op inside {cdo_pkg::fractional_quotient, cdo_pkg::long_signed_quotient,
		cdo_pkg::long_unsigned_quotient, cdo_pkg::short_signed_quotient,
		cdo_pkg::short_unsigned_quotient, cdo_pkg::preserving_fractional_quotient,
		cdo_pkg::preserving_signed_quotient, cdo_pkg::preserving_long_signed_quotient};
	assign hold_k = src_val[HOLD_W-1:0];
	assign src_ctx = src_val[2:0];

	// ----------------------------------------------------------------
	// Shared subtractor, comparator and decimal adjuster.
	// ----------------------------------------------------------------
	always_comb begin
		sub_b = src_val;
		sub_cin = 1'b1;
		case (op)
			cdo_pkg::zero_test_op: sub_b = `CDO_ZERO;
			cdo_pkg::borrow_test_op: sub_cin = c_flag;
			cdo_pkg::minus_one_op: sub_b = `CDO_ONE;
			cdo_pkg::minus_two_op: sub_b = `CDO_TWO;
			default: ;
		endcase
		sub_sum = {1'b0, base_val} + {1'b0, ~sub_b} + {16'h0000, sub_cin};
		lo_sum = {1'b0, base_val[7:0]} + {1'b0, ~sub_b[7:0]} + {8'h00, sub_cin};
		sub_ov = (base_val[15] != sub_b[15]) && (sub_sum[15] != base_val[15]);
		case (op)
			cdo_pkg::skip_on_equal, cdo_pkg::branch_on_equal: cmp_hit = base_val == src_val;
			cdo_pkg::skip_on_greater, cdo_pkg::branch_on_greater:
				cmp_hit = $signed(base_val) > $signed(src_val);
			cdo_pkg::skip_on_less, cdo_pkg::branch_on_less:
				cmp_hit = $signed(base_val) < $signed(src_val);
			cdo_pkg::skip_on_unequal, cdo_pkg::branch_on_unequal: cmp_hit = base_val != src_val;
			default: cmp_hit = 1'b0;
		endcase
		bcd = {1'b0, base_val[7:0]};
		bcd_c = c_flag;
		if (half_carry_flag || (bcd[3:0] > `CDO_BCD_MAX)) begin
			bcd = bcd + `CDO_BCD_LO_FIX;
		end
		if (bcd_c || bcd[8] || (bcd[7:4] > `CDO_BCD_MAX)) begin
			bcd = bcd + `CDO_BCD_HI_FIX;
			bcd_c = 1'b1;
		end
	end

	// Dividend shaping for the divide engine.
	always_comb begin
		div.start = accept && is_div;
		div.divisor = src_val;
		div.is_signed = 1'b1;
		div.dividend = {{16{base_val[15]}}, base_val};
		case (op)
			cdo_pkg::long_signed_quotient, cdo_pkg::preserving_long_signed_quotient:
				div.dividend = {base_hi, base_val};
			cdo_pkg::long_unsigned_quotient: begin
				div.dividend = {base_hi, base_val};
				div.is_signed = 1'b0;
			end
			cdo_pkg::short_unsigned_quotient: begin
				div.dividend = {`CDO_ZERO, base_val};
				div.is_signed = 1'b0;
			end
			cdo_pkg::fractional_quotient, cdo_pkg::preserving_fractional_quotient:
				div.dividend = {base_val[15], base_val, `CDO_FRAC_PAD};
			default: ;
		endcase
	end

	// ----------------------------------------------------------------
	// Execution sequencing, results and flags.
	// ----------------------------------------------------------------
	always_comb begin
		next_cnt = (cnt == 3'h0) ? cnt : 3'(cnt - 3'h1);
		next_pend_we = pend_we;
		next_pend_pair = pend_pair;
		next_pend_skip = pend_skip;
		next_pend_br = pend_br;
		next_result = result;
		next_remainder = remainder;
		next_ctx = ctx;
		next_c = c_flag;
		next_dc = half_carry_flag;
		next_n = n_flag;
		next_ov = signed_wrap_flag;
		next_z = z_flag;
		next_oa = accum_a_overflow;
		next_ob = accum_b_overflow;
		next_sa = accum_a_clip_flag;
		next_sb = accum_b_clip_flag;
		upd_arith = 1'b0;
		if (accept) begin
			next_pend_we = 1'b0;
			next_pend_pair = 1'b0;
			next_pend_skip = 1'b0;
			next_pend_br = 1'b0;
			next_cnt = 3'(`CDO_CYC_BASE + {2'h0, op_sfr}); // RULE15
			case (op)
				cdo_pkg::zero_out_op: begin
					next_result = `CDO_ZERO; // RULE17
					next_pend_we = 1'b1;
				end
				cdo_pkg::zero_out_acc: begin
					if (acc_sel) begin
						next_ob = 1'b0; // RULE17
						next_sb = 1'b0;
					end else begin
						next_oa = 1'b0; // RULE17
						next_sa = 1'b0;
					end
				end
				cdo_pkg::invert_op: begin
					next_result = ~base_val; // RULE19
					next_pend_we = 1'b1;
					next_n = ~base_val[15];
					next_z = base_val == `CDO_ALL_ONES;
				end
				cdo_pkg::magnitude_test_op, cdo_pkg::zero_test_op, cdo_pkg::borrow_test_op:
					upd_arith = 1'b1; // RULE1 RULE2 RULE3 RULE4
				cdo_pkg::minus_one_op, cdo_pkg::minus_two_op: begin
					upd_arith = 1'b1; // RULE18
					next_result = sub_sum[15:0];
					next_pend_we = 1'b1;
				end
				cdo_pkg::skip_on_equal, cdo_pkg::skip_on_greater, cdo_pkg::skip_on_less,
				cdo_pkg::skip_on_unequal: begin
					if (cmp_hit) begin
						next_pend_skip = 1'b1; // RULE5 RULE6
						next_cnt = next_two_word ? `CDO_CYC_SKIP_LONG : `CDO_CYC_SKIP;
					end
				end
				cdo_pkg::branch_on_equal, cdo_pkg::branch_on_greater, cdo_pkg::branch_on_less,
				cdo_pkg::branch_on_unequal: begin
					if (cmp_hit) begin
						next_pend_br = 1'b1; // RULE7 RULE8
						next_cnt = `CDO_CYC_BRANCH;
					end
				end
				cdo_pkg::register_bank_switch: begin
					next_ctx = src_val[2:0]; // RULE9 RULE10
					next_cnt = `CDO_CYC_CTX;
				end
				cdo_pkg::bcd_adjust_byte: begin
					next_result = {base_val[15:8], bcd[7:0]}; // RULE11
					next_c = bcd_c;
					next_pend_we = 1'b1;
				end
				cdo_pkg::irq_hold_for_cycles: ;
				default: begin
					next_cnt = `CDO_CYC_DIV; // RULE13 RULE14
					next_pend_pair = !(op inside {cdo_pkg::preserving_fractional_quotient,
						cdo_pkg::preserving_signed_quotient,
						cdo_pkg::preserving_long_signed_quotient}); // RULE16
					next_pend_we = !next_pend_pair;
				end
			endcase
			if (upd_arith) begin
				next_c = sub_sum[16];
				next_dc = lo_sum[8];
				next_n = sub_sum[15];
				next_ov = sub_ov;
				// Borrow chains only ever clear zero, so a multiword compare stays correct.
				next_z = (op == cdo_pkg::borrow_test_op) ? (z_flag && sub_sum[15:0] == `CDO_ZERO) :
					(sub_sum[15:0] == `CDO_ZERO); // RULE3
			end
		end
		if (div.valid) begin
			next_result = div.quotient; // RULE13 RULE14
			next_remainder = div.remainder;
			next_n = div.quotient[15];
			next_z = div.quotient == `CDO_ZERO;
			next_c = div.rem_nz;
			next_ov = div.ovf;
		end
		next_busy = next_cnt != 3'h0;
		next_done = next_cnt == 3'h1;
		next_ready = next_cnt <= 3'h1;
		next_result_we = next_done && next_pend_we;
		next_pair_we = next_done && next_pend_pair;
		next_skip = next_done && next_pend_skip;
		next_branch = next_done && next_pend_br;
	end

	// Interrupt hold counter.
	always_comb begin
		next_hold = (hold == '0) ? hold : HOLD_W'(hold - 1'b1);
		if (accept && op == cdo_pkg::irq_hold_for_cycles) begin
			next_hold = hold_k; // RULE12
		end
		next_blocked = next_hold != '0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
			pend_we <= 1'b0;
			pend_pair <= 1'b0;
			pend_skip <= 1'b0;
			pend_br <= 1'b0;
			op_ready <= 1'b1;
			busy <= 1'b0;
			done <= 1'b0;
			skip_taken <= 1'b0;
			branch_taken <= 1'b0;
			result <= `CDO_ZERO;
			result_we <= 1'b0;
			remainder <= `CDO_ZERO;
			pair_we <= 1'b0;
			ctx <= `CDO_CTX_RESET;
			c_flag <= 1'b0;
			half_carry_flag <= 1'b0;
			n_flag <= 1'b0;
			signed_wrap_flag <= 1'b0;
			z_flag <= 1'b0;
			accum_a_overflow <= 1'b0;
			accum_b_overflow <= 1'b0;
			accum_a_clip_flag <= 1'b0;
			accum_b_clip_flag <= 1'b0;
			hold <= '0;
			irq_blocked <= 1'b0;
		end else begin
			cnt <= next_cnt;
			pend_we <= next_pend_we;
			pend_pair <= next_pend_pair;
			pend_skip <= next_pend_skip;
			pend_br <= next_pend_br;
			op_ready <= next_ready;
			busy <= next_busy;
			done <= next_done;
			skip_taken <= next_skip;
			branch_taken <= next_branch;
			result <= next_result;
			result_we <= next_result_we;
			remainder <= next_remainder;
			pair_we <= next_pair_we;
			ctx <= next_ctx;
			c_flag <= next_c;
			half_carry_flag <= next_dc;
			n_flag <= next_n;
			signed_wrap_flag <= next_ov;
			z_flag <= next_z;
			accum_a_overflow <= next_oa;
			accum_b_overflow <= next_ob;
			accum_a_clip_flag <= next_sa;
			accum_b_clip_flag <= next_sb;
			hold <= next_hold;
			irq_blocked <= next_blocked;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_zero_test_flags: assert property ( // RULE1
		accept && op == cdo_pkg::zero_test_op && !op_sfr |=>
			done && !result_we && z_flag == ($past(base_val) == `CDO_ZERO)
	) else $error("zero test result wrong");
	a_mag_test_carry: assert property ( // RULE2
		accept && op == cdo_pkg::magnitude_test_op |-> ##1 !result_we &&
			c_flag == ($past(base_val) >= $past(src_val))
	) else $error("magnitude test carry wrong");
	a_borrow_z_sticky: assert property ( // RULE3
		accept && op == cdo_pkg::borrow_test_op && !z_flag |=> !z_flag
	) else $error("borrow test set zero");
	a_borrow_sfr_slow: assert property ( // RULE4 RULE15
		accept && op == cdo_pkg::borrow_test_op && op_sfr |=> !done ##1 (done && !result_we)
	) else $error("peripheral operand cycle missing");
	a_skip_eq_time: assert property ( // RULE5
		accept && op == cdo_pkg::skip_on_equal && cmp_hit && !next_two_word |=>
			!done ##1 (done && skip_taken)
	) else $error("equal skip timing wrong");
	a_skip_long_time: assert property ( // RULE6
		accept && cmp_hit && next_two_word && op inside {cdo_pkg::skip_on_greater,
			cdo_pkg::skip_on_less, cdo_pkg::skip_on_unequal} |=>
			!done ##1 !done ##1 (done && skip_taken && c_flag == $past(c_flag, 3))
	) else $error("skip timing or flags wrong");
	a_branch_taken: assert property ( // RULE7
		accept && cmp_hit && op == cdo_pkg::branch_on_equal |=>
			(!done)[*4] ##1 (done && branch_taken && z_flag == $past(z_flag, 5))
	) else $error("taken branch timing wrong");
	a_branch_not_taken: assert property ( // RULE8
		accept && !cmp_hit && !op_sfr && op inside {cdo_pkg::branch_on_greater,
			cdo_pkg::branch_on_less, cdo_pkg::branch_on_unequal} |=> done && !branch_taken
	) else $error("untaken branch timing wrong");
	a_ctx_switch: assert property ( // RULE9 RULE10
		accept && op == cdo_pkg::register_bank_switch |=> ctx == $past(src_ctx) && !done ##1 done
	) else $error("context switch wrong");
	a_bcd_only_c: assert property ( // RULE11
		accept && op == cdo_pkg::bcd_adjust_byte |=> n_flag == $past(n_flag) &&
			z_flag == $past(z_flag) && signed_wrap_flag == $past(signed_wrap_flag) && result_we
	) else $error("decimal adjust touched other flags");
	a_hold_load: assert property ( // RULE12
		accept && op == cdo_pkg::irq_hold_for_cycles && hold_k != '0 |=>
			irq_blocked && hold == $past(hold_k)
	) else $error("interrupt hold not loaded");
	a_div_long_keep: assert property ( // RULE13
		accept && op == cdo_pkg::preserving_long_signed_quotient |=>
			(!done)[*5] ##1 (done && result_we && !pair_we)
	) else $error("preserving long divide wrong");
	a_div_frac_keep: assert property ( // RULE14
		accept && op == cdo_pkg::preserving_fractional_quotient |=>
			(!done)[*5] ##1 (done && result_we && !pair_we)
	) else $error("preserving fractional divide wrong");
	a_zero_out_write: assert property ( // RULE17
		accept && op == cdo_pkg::zero_out_op && !op_sfr |=> result_we && result == `CDO_ZERO
	) else $error("zero out wrong");
	a_minus_two_value: assert property ( // RULE18
		accept && op == cdo_pkg::minus_two_op && !op_sfr |=>
			result_we && result == $past(base_val) - `CDO_TWO
	) else $error("minus two wrong");
	a_invert_flags: assert property ( // RULE19
		accept && op == cdo_pkg::invert_op |=> result == ~$past(base_val) &&
			c_flag == $past(c_flag) && half_carry_flag == $past(half_carry_flag)
	) else $error("invert wrong");
endmodule

// ### core/cdo_params.svh
`ifndef CDO_PARAMS_SVH
`define CDO_PARAMS_SVH
`define CDO_ZERO 16'h0000
`define CDO_ONE 16'h0001
`define CDO_TWO 16'h0002
`define CDO_ALL_ONES 16'hffff
`define CDO_CYC_BASE 3'h1
`define CDO_CYC_SKIP 3'h2
`define CDO_CYC_SKIP_LONG 3'h3
`define CDO_CYC_BRANCH 3'h5
`define CDO_CYC_CTX 3'h2
`define CDO_CYC_DIV 3'h6
`define CDO_CTX_RESET 3'h0
`define CDO_HOLD_W 14
`define CDO_DIV_LAST_STEP 2'h3
`define CDO_DIV_BITS 8
`define CDO_FRAC_PAD 15'h0000
`define CDO_BCD_MAX 4'h9
`define CDO_BCD_LO_FIX 9'h006
`define CDO_BCD_HI_FIX 9'h060
`endif

// ### core/cdo_pkg.sv
package cdo_pkg;
	typedef enum logic [4:0] {
		zero_out_op = 5'h00,
		zero_out_acc = 5'h01,
		invert_op = 5'h02,
		magnitude_test_op = 5'h03,
		zero_test_op = 5'h04,
		borrow_test_op = 5'h05,
		skip_on_equal = 5'h06,
		skip_on_greater = 5'h07,
		skip_on_less = 5'h08,
		skip_on_unequal = 5'h09,
		branch_on_equal = 5'h0a,
		branch_on_greater = 5'h0b,
		branch_on_less = 5'h0c,
		branch_on_unequal = 5'h0d,
		register_bank_switch = 5'h0e,
		bcd_adjust_byte = 5'h0f,
		minus_one_op = 5'h10,
		minus_two_op = 5'h11,
		irq_hold_for_cycles = 5'h12,
		fractional_quotient = 5'h13,
		long_signed_quotient = 5'h14,
		long_unsigned_quotient = 5'h15,
		short_signed_quotient = 5'h16,
		short_unsigned_quotient = 5'h17,
		preserving_fractional_quotient = 5'h18,
		preserving_signed_quotient = 5'h19,
		preserving_long_signed_quotient = 5'h1a
	} cdo_op_e;

	typedef enum logic [1:0] {
		div_idle = 2'b00,
		div_iter = 2'b01,
		div_fix = 2'b11
	} cdo_div_state_e;
endpackage

// ### core/cdo_div_if.sv
interface cdo_div_if;
	logic start;
	logic is_signed;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic valid;
	logic [15:0] quotient;
	logic [15:0] remainder;
	logic ovf;
	logic rem_nz;
	modport ctrl(output start, is_signed, dividend, divisor,
		input valid, quotient, remainder, ovf, rem_nz);
	modport engine(input start, is_signed, dividend, divisor,
		output valid, quotient, remainder, ovf, rem_nz);
endinterface

// ### core/cdo_divider.sv
`include "cdo_params.svh"
module cdo_divider (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Engine side of the divide link
	cdo_div_if.engine dv
);
	cdo_pkg::cdo_div_state_e state;
	cdo_pkg::cdo_div_state_e next_state;
	logic [1:0] step;
	logic [1:0] next_step;
	logic [31:0] quo;
	logic [31:0] next_quo;
	logic [15:0] rem;
	logic [15:0] next_rem;
	logic [15:0] dvs;
	logic [15:0] next_dvs;
	logic neg_q;
	logic next_neg_q;
	logic neg_r;
	logic next_neg_r;
	logic sgn;
	logic next_sgn;
	logic [31:0] q_fix;
	logic [15:0] rem_ch [0:`CDO_DIV_BITS];
	logic [31:0] quo_ch [0:`CDO_DIV_BITS];

	// ----------------------------------------------------------------
	// Restoring steps, eight quotient bits per cycle.
	// ----------------------------------------------------------------
	assign rem_ch[0] = rem;
	assign quo_ch[0] = quo;
	for (genvar g = 0; g < `CDO_DIV_BITS; g++) begin : g_step
		logic [16:0] trial;
		logic fits;
		assign trial = {rem_ch[g], quo_ch[g][31]};
		assign fits = trial >= {1'b0, dvs};
		assign rem_ch[g + 1] = fits ? 16'(trial - {1'b0, dvs}) : trial[15:0];
		assign quo_ch[g + 1] = {quo_ch[g][30:0], fits};
	end

	always_comb begin
		next_state = state;
		next_step = step;
		next_quo = quo;
		next_rem = rem;
		next_dvs = dvs;
		next_neg_q = neg_q;
		next_neg_r = neg_r;
		next_sgn = sgn;
		case (state)
			cdo_pkg::div_idle: begin
				if (dv.start) begin
					next_sgn = dv.is_signed;
					next_neg_r = dv.is_signed && dv.dividend[31];
					next_neg_q = next_neg_r ^ (dv.is_signed && dv.divisor[15]);
					next_quo = next_neg_r ? -dv.dividend : dv.dividend;
					next_dvs = (dv.is_signed && dv.divisor[15]) ? -dv.divisor : dv.divisor;
					next_rem = `CDO_ZERO;
					next_step = 2'h0;
					next_state = cdo_pkg::div_iter;
				end
			end
			cdo_pkg::div_iter: begin
				next_quo = quo_ch[`CDO_DIV_BITS];
				next_rem = rem_ch[`CDO_DIV_BITS];
				next_step = 2'(step + 2'h1);
				if (step == `CDO_DIV_LAST_STEP) begin
					next_state = cdo_pkg::div_fix;
				end
			end
			default: next_state = cdo_pkg::div_idle;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= cdo_pkg::div_idle;
			step <= 2'h0;
			quo <= 32'h00000000;
			rem <= `CDO_ZERO;
			dvs <= `CDO_ZERO;
			neg_q <= 1'b0;
			neg_r <= 1'b0;
			sgn <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			quo <= next_quo;
			rem <= next_rem;
			dvs <= next_dvs;
			neg_q <= next_neg_q;
			neg_r <= next_neg_r;
			sgn <= next_sgn;
		end
	end

	// Results are valid during the single fix-up cycle.
	assign q_fix = neg_q ? -quo : quo;
	assign dv.valid = state == cdo_pkg::div_fix;
	assign dv.quotient = q_fix[15:0];
	assign dv.remainder = neg_r ? -rem : rem;
	assign dv.rem_nz = rem != `CDO_ZERO;
	assign dv.ovf = (dvs == `CDO_ZERO) ||
		(sgn ? (q_fix[31:15] != {17{q_fix[15]}}) : (quo[31:16] != `CDO_ZERO));

	a_div_step_count: assert property ( // RULE13
		@(posedge core_clk) disable iff (!rst_n)
		dv.start && state == cdo_pkg::div_idle |=>
			(state == cdo_pkg::div_iter)[*4] ##1 state == cdo_pkg::div_fix
	) else $error("divide engine did not take four steps");
endmodule

// ### test/cdo_exec_tb.sv
module cdo_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Design hookup
	// ----------------------------------------
	logic core_clk, rst_n, op_valid, acc_sel, op_sfr, next_two_word;
	cdo_pkg::cdo_op_e op;
	logic [15:0] base_val, base_hi, src_val, result, remainder;
	logic op_ready, busy, done, skip_taken, branch_taken, result_we, pair_we, irq_blocked;
	logic [2:0] ctx;
	logic c_flag, half_carry_flag, n_flag, signed_wrap_flag, z_flag;
	logic accum_a_overflow, accum_b_overflow, accum_a_clip_flag, accum_b_clip_flag;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc, irq0;
	int irq_cnt = 0;
	logic sk, br, we, pw, bz;
	logic [15:0] f0;
	cdo_exec uut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
		.base_val(base_val), .base_hi(base_hi), .src_val(src_val), .acc_sel(acc_sel),
		.op_sfr(op_sfr), .next_two_word(next_two_word), .op_ready(op_ready), .busy(busy),
		.done(done), .skip_taken(skip_taken), .branch_taken(branch_taken), .result(result),
		.result_we(result_we), .remainder(remainder), .pair_we(pair_we), .ctx(ctx),
		.irq_blocked(irq_blocked), .c_flag(c_flag), .half_carry_flag(half_carry_flag),
		.n_flag(n_flag), .signed_wrap_flag(signed_wrap_flag), .z_flag(z_flag),
		.accum_a_overflow(accum_a_overflow), .accum_b_overflow(accum_b_overflow),
		.accum_a_clip_flag(accum_a_clip_flag), .accum_b_clip_flag(accum_b_clip_flag));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(negedge core_clk) if (irq_blocked === 1'b1) irq_cnt++;
	function automatic logic [15:0] fl();
		return {11'h000, c_flag, half_carry_flag, n_flag, signed_wrap_flag, z_flag};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h got %h", nm, e, g);
		end
	endtask
	// Issues one operation and waits, bounded, for its completion pulse.
	task automatic run(input cdo_pkg::cdo_op_e o, input logic [15:0] b, input logic [15:0] h,
			input logic [15:0] s, input logic sfr, input logic two);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op <= o;
		base_val <= b;
		base_hi <= h;
		src_val <= s;
		op_sfr <= sfr;
		next_two_word <= two;
		@(posedge core_clk);
		op_valid <= 1'b0;
		cyc = 0;
		do begin
			@(negedge core_clk);
			cyc++;
		end while (done !== 1'b1 && cyc < 20);
		sk = skip_taken;
		br = branch_taken;
		we = result_we;
		pw = pair_we;
		bz = busy;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		results();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		cdo_pkg::cdo_op_e so[8];
		logic [15:0] b, s;
		logic t;
		so = '{cdo_pkg::skip_on_equal, cdo_pkg::skip_on_greater, cdo_pkg::skip_on_less,
			cdo_pkg::skip_on_unequal, cdo_pkg::branch_on_equal, cdo_pkg::branch_on_greater,
			cdo_pkg::branch_on_less, cdo_pkg::branch_on_unequal};
		rst_n = 1'b0;
		op_valid = 1'b0;
		op = cdo_pkg::zero_out_op;
		{base_val, base_hi, src_val} = '0;
		{acc_sel, op_sfr, next_two_word} = '0;
		repeat (3) @(posedge core_clk);
		chk("ready", 16'h0001, {15'h0000, op_ready});
		chk("ctx", 16'h0000, {13'h0000, ctx});
		rst_n <= 1'b1;
		run(cdo_pkg::zero_test_op, 16'h8000, 16'h0000, 16'h8000, 1'b0, 1'b0);
		chk("flags", 16'h001c, fl());
		chk("cyc", 16'h0001, 16'(cyc));
		chk("we", 16'h0000, {15'h0000, we});
		chk("busy", 16'h0001, {15'h0000, bz});
		run(cdo_pkg::zero_test_op, 16'h8000, 16'h0000, 16'h8000, 1'b1, 1'b0);
		chk("cyc", 16'h0002, 16'(cyc));
		run(cdo_pkg::magnitude_test_op, 16'h8000, 16'h0000, 16'h0001, 1'b0, 1'b0);
		chk("flags", 16'h0012, fl());
		chk("we", 16'h0000, {15'h0000, we});
		run(cdo_pkg::magnitude_test_op, 16'h0003, 16'h0000, 16'h0003, 1'b0, 1'b0);
		chk("flags", 16'h0019, fl());
		run(cdo_pkg::borrow_test_op, 16'h0003, 16'h0000, 16'h0003, 1'b0, 1'b0);
		chk("flags", 16'h0019, fl());
		run(cdo_pkg::borrow_test_op, 16'h0000, 16'h0000, 16'h0001, 1'b1, 1'b0);
		chk("flags", 16'h0004, fl());
		chk("cyc", 16'h0002, 16'(cyc));
		run(cdo_pkg::borrow_test_op, 16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
		chk("flags", 16'h0018, fl());
		chk("cyc", 16'h0001, 16'(cyc));
		$display("test compare done");
		f0 = fl();
		for (int i = 0; i < 8; i++) begin
			for (int p = 0; p < 2; p++) begin
				b = p ? 16'h0005 : (i % 4 == 2) ? 16'hffff : 16'h0001;
				s = p ? 16'h0005 : (i % 4 == 2) ? 16'h0001 : 16'hffff;
				t = (i % 4 == 0) ? (b == s) : (i % 4 == 1) ? ($signed(b) > $signed(s)) :
					(i % 4 == 2) ? ($signed(b) < $signed(s)) : (b != s);
				run(so[i], b, 16'h0000, s, 1'b0, !p[0]);
				chk("taken", {15'h0000, t}, {15'h0000, (i < 4) ? sk : br});
				chk("busy", 16'h0001, {15'h0000, bz});
				chk("cyc", !t ? 16'h0001 : (i >= 4) ? 16'h0005 : p ? 16'h0002 : 16'h0003,
					16'(cyc));
				chk("flags", f0, fl());
			end
		end
		$display("test skip and branch done");
		run(cdo_pkg::register_bank_switch, 16'h0000, 16'h0000, 16'h0005, 1'b0, 1'b0);
		chk("ctx", 16'h0005, {13'h0000, ctx});
		chk("cyc", 16'h0002, 16'(cyc));
		run(cdo_pkg::register_bank_switch, 16'h0000, 16'h0000, 16'h0007, 1'b0, 1'b0);
		chk("ctx", 16'h0007, {13'h0000, ctx});
		chk("flags", f0, fl());
		run(cdo_pkg::magnitude_test_op, 16'h0000, 16'h0000, 16'h0101, 1'b0, 1'b0);
		run(cdo_pkg::bcd_adjust_byte, 16'h129b, 16'h0000, 16'h129b, 1'b0, 1'b0);
		chk("result", 16'h1201, result);
		chk("flags", 16'h0014, fl());
		chk("cyc", 16'h0001, 16'(cyc));
		irq0 = irq_cnt;
		run(cdo_pkg::irq_hold_for_cycles, 16'h0000, 16'h0000, 16'h0003, 1'b0, 1'b0);
		repeat (8) @(negedge core_clk);
		chk("hold", 16'h0003, 16'(irq_cnt - irq0));
		chk("flags", 16'h0014, fl());
		$display("test context bcd hold done");
		run(cdo_pkg::minus_two_op, 16'h0001, 16'h0000, 16'h0001, 1'b0, 1'b0);
		chk("result", 16'hffff, result);
		chk("flags", 16'h0004, fl());
		chk("we", 16'h0001, {15'h0000, we});
		run(cdo_pkg::minus_one_op, 16'h8000, 16'h0000, 16'h8000, 1'b1, 1'b0);
		chk("result", 16'h7fff, result);
		chk("flags", 16'h0012, fl());
		chk("cyc", 16'h0002, 16'(cyc));
		run(cdo_pkg::invert_op, 16'h00ff, 16'h0000, 16'h00ff, 1'b0, 1'b0);
		chk("result", 16'hff00, result);
		chk("flags", 16'h0016, fl());
		run(cdo_pkg::zero_out_op, 16'h1234, 16'h0000, 16'h1234, 1'b0, 1'b0);
		chk("result", 16'h0000, result);
		chk("we", 16'h0001, {15'h0000, we});
		run(cdo_pkg::zero_out_acc, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		chk("acc", 16'h0000, {12'h000, accum_a_overflow, accum_b_overflow,
			accum_a_clip_flag, accum_b_clip_flag});
		$display("test write ops done");
		run(cdo_pkg::preserving_long_signed_quotient, 16'h0064, 16'h0000, 16'h0007, 1'b1, 1'b0);
		chk("quot", 16'h000e, result);
		chk("rem", 16'h0002, remainder);
		chk("flags", 16'h0010, fl());
		chk("cyc", 16'h0006, 16'(cyc));
		chk("pair", 16'h0000, {15'h0000, pw});
		run(cdo_pkg::preserving_long_signed_quotient, 16'hff9c, 16'hffff, 16'h0007, 1'b0, 1'b0);
		chk("quot", 16'hfff2, result);
		chk("rem", 16'hfffe, remainder);
		chk("flags", 16'h0014, fl());
		run(cdo_pkg::preserving_fractional_quotient, 16'h2000, 16'h0000, 16'h4000, 1'b0, 1'b0);
		chk("quot", 16'h4000, result);
		chk("flags", 16'h0000, fl());
		chk("cyc", 16'h0006, 16'(cyc));
		chk("pair", 16'h0000, {15'h0000, pw});
		run(cdo_pkg::preserving_signed_quotient, 16'h0005, 16'h0000, 16'h0000, 1'b0, 1'b0);
		chk("ov", 16'h0001, {15'h0000, signed_wrap_flag});
		run(cdo_pkg::long_unsigned_quotient, 16'h0000, 16'h0001, 16'h0002, 1'b0, 1'b0);
		chk("quot", 16'h8000, result);
		chk("pair", 16'h0001, {15'h0000, pw});
		chk("cyc", 16'h0006, 16'(cyc));
		run(cdo_pkg::short_unsigned_quotient, 16'hfff0, 16'hffff, 16'h0010, 1'b0, 1'b0);
		chk("quot", 16'h0fff, result);
		chk("pair", 16'h0001, {15'h0000, pw});
		$display("test divide done");
		results();
	end
endmodule
